// [src/line_irq_defs.svh]
// constants for the line status and fault interrupt block
`ifndef LINE_IRQ_DEFS_SVH
`define LINE_IRQ_DEFS_SVH

// ======================================================
// channels and lock measurement
`define CH_COUNT        2
`define LOCK_TOL_PPM    100
`define PPM_SCALE       1000000
`define LOCK_WIN_TICKS  20000
`define LOCK_CNT_W      16

// ======================================================
// register map
`define APB_ADDR_W      8
`define REG_FAULT_STAT  8'h00
`define REG_FAULT_EN    8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_CLEAR   8'h0c
`define REG_IRQ_ENABLE  8'h10

// ======================================================
// reset values
`define FAULT_EN_RESET  4'h5
`define IRQ_EN_RESET    8'h00

// ======================================================
// fault status fields, two bits each
`define FS_TX_LOCK_LOST_BIT_PEND   0
`define FS_FIERR_PEND   2
`define FS_TX_LOCK_LOST_BIT_LIVE   4
`define FS_LOS_LIVE     6
`define FS_LOL_LIVE     8
`define FS_REF_SEL      10
`define FS_IRQ_N        12

// fault enable fields inside each channel pair
`define FEN_TX_LOCK_LOST_BIT       0
`define FEN_FIERR       1

// sticky event fields, two bits each
`define EV_LOS          0
`define EV_LOL          2
`define EV_TX_LOCK_LOST_BIT        4
`define EV_FIERR        6

`endif

// [src/line_irq_pkg.sv]
// types for the line status and fault interrupt block
package line_irq_pkg;

   // ======================================================
   // reference frequency selection
   typedef enum logic [1:0] {
      ref_sel_low,
      ref_sel_float,
      ref_sel_high
   } ref_sel_e;

   // ======================================================
   // pins after synchronisation
   typedef struct packed {
      logic       por_n;
      logic [1:0] ref_sel;
      logic       ref_level;
      logic [1:0] rec_mark;
      logic [1:0] realign;
      logic [1:0] fierr;
      logic [1:0] tx_lol;
      logic [1:0] los;
   } line_pins_s;

   // ======================================================
   // state of the controller
   typedef struct packed {
      logic        started;
      ref_sel_e    ref_sel;
      logic [1:0]  tx_lock_lost_bit_pend;
      logic [1:0]  fierr_pend;
      logic [1:0]  tx_irq_n;
      logic [3:0]  fault_en;
      logic [7:0]  ev_sticky;
      logic [7:0]  irq_en;
      logic        irq;
      logic [31:0] prdata;
      logic        pslverr;
      logic [1:0]  lol_prev;
      line_pins_s  prev;
   } ctl_state_s;

endpackage

// [src/pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } sync_s;

   sync_s q;
   sync_s d;

   // ======================================================
   // stages
   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // s1 is left alone: it may still be metastable
      d.filt = (q.s2 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
      if (reset) begin
         d = '0;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign pin_out = q.filt;

endmodule // pin_sync

// [src/ppm_lock_monitor.sv]
// frequency comparison of recovered marks against reference marks
`timescale 1ns/100ps
`include "line_irq_defs.svh"
module ppm_lock_monitor #(
   parameter int WIN_TICKS = `LOCK_WIN_TICKS,
   parameter int TOL_PPM   = `LOCK_TOL_PPM,
   parameter int CNT_W     = `LOCK_CNT_W
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ref_tick,
   input  wire logic rec_tick,
   output logic      lock_lost
);

   localparam int TOL = WIN_TICKS * TOL_PPM / `PPM_SCALE;
   localparam logic [CNT_W-1:0] WIN_END = CNT_W'(WIN_TICKS - 1);
   localparam logic [CNT_W-1:0] LO_LIM  = CNT_W'(WIN_TICKS - TOL);
   localparam logic [CNT_W-1:0] HI_LIM  = CNT_W'(WIN_TICKS + TOL);

   typedef struct packed {
      logic [CNT_W-1:0] ref_cnt;
      logic [CNT_W-1:0] rec_cnt;
      logic             lost;
   } mon_s;

   mon_s             q;
   mon_s             d;
   logic [CNT_W-1:0] ref_now;
   logic             win_end;
   logic             out_of_tol;

   assign ref_now    = q.ref_cnt + CNT_W'(ref_tick);
   assign win_end    = rec_tick && (q.rec_cnt == WIN_END);
   assign out_of_tol = (ref_now < LO_LIM) || (ref_now > HI_LIM);

   // ======================================================
   // window counting
   always_comb begin
      d = q;
      d.ref_cnt = ref_now;
      if (win_end) begin
         d.lost    = out_of_tol;
         d.ref_cnt = '0;
         d.rec_cnt = '0;
      end else if (ref_now > HI_LIM) begin
         // recovered marks stopped: no need to wait for them
         d.lost    = 1'b1;
         d.ref_cnt = '0;
         d.rec_cnt = '0;
      end else if (rec_tick) begin
         d.rec_cnt = q.rec_cnt + 1'b1;
      end
      if (reset) begin
         d      = '0;
         d.lost = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign lock_lost = q.lost;

   // ======================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_bad_win;
      win_end && out_of_tol;
   endsequence

   sequence s_good_win;
      win_end && !out_of_tol;
   endsequence

   AST_LOCK_DRIFT: assert property (
      s_bad_win |=> lock_lost)
      else $error("lock not flagged after drifting window");

   AST_LOCK_REGAIN: assert property (
      s_good_win |=> !lock_lost)
      else $error("lock lost flagged after good window");

endmodule // ppm_lock_monitor

// [src/line_status_and_fault_irq.sv]
// line status outputs and transmit fault interrupts behind apb
`timescale 1ns/100ps
`include "line_irq_defs.svh"
// Function
// - signal-lost output follows the receiver's loss report per channel
// - lock lost when recovered clock is over 100 ppm from reference
// - fault interrupt goes low on an enabled transmitter error event
// - a status register read releases pending transmit fault interrupts
// - a fifo realign pulse clears an interrupt caused by fifo error
// - transmit lock-lost bit falling clears the fault interrupt
// - after reset only transmit lock loss may raise the fault interrupt
// - receiver fault interrupt outputs stay deasserted, being reserved
// - power-on reset pin is active low and holds logic in reset
// - reference selection is sampled only at power-up or reset release
// - asserting fifo realign also clears that channel's fifo error bit
module line_status_and_fault_irq #(
   parameter int ADDR_W    = `APB_ADDR_W,
   parameter int WIN_TICKS = `LOCK_WIN_TICKS
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   input  wire logic              power_on_reset_n,
   input  wire logic              ref_clock_in_pos,
   input  wire logic              ref_clock_in_neg,
   input  wire logic [1:0]        ref_freq_select,
   input  wire logic [1:0]        rx_los_detect,
   input  wire logic [1:0]        rec_clock_mark,
   input  wire logic [1:0]        tx_cdr_lock_lost,
   input  wire logic [1:0]        fifo_error_flag,
   input  wire logic [1:0]        fifo_realign_ctl,
   output logic      [1:0]        rx_signal_lost_out,
   output logic      [1:0]        rx_lock_lost_out,
   output logic      [1:0]        tx_fault_irq_n,
   output logic      [1:0]        rx_fault_irq_n
);

   // ======================================================
   // pin synchronisation
   line_irq_pkg::line_pins_s pins_raw;
   line_irq_pkg::line_pins_s pins_f;

   // differential: pos high, neg low; single-ended: neg tied low.
   // the mark inputs must toggle well below a quarter of clk.
   always_comb begin
      pins_raw           = '0;
      pins_raw.por_n     = power_on_reset_n;
      pins_raw.ref_sel   = ref_freq_select;
      pins_raw.ref_level = ref_clock_in_pos & ~ref_clock_in_neg;
      pins_raw.rec_mark  = rec_clock_mark;
      pins_raw.realign   = fifo_realign_ctl;
      pins_raw.fierr     = fifo_error_flag;
      pins_raw.tx_lol    = tx_cdr_lock_lost;
      pins_raw.los       = rx_los_detect;
   end

   pin_sync #(
      .WIDTH   ($bits(line_irq_pkg::line_pins_s))
   ) u_pin_sync (
      .clk     (clk),
      .reset   (reset),
      .pin_in  (pins_raw),
      .pin_out (pins_f)
   );

   // ======================================================
   // internal reset
   logic rst_int;

   assign rst_int = reset | ~pins_f.por_n;

   // ======================================================
   // state and edges
   line_irq_pkg::ctl_state_s st_q;
   line_irq_pkg::ctl_state_s st_d;

   logic       ref_tick;
   logic [1:0] rec_tick;
   logic [1:0] lol;
   logic [1:0] lol_rise;
   logic [1:0] los_rise;
   logic [1:0] tx_lock_lost_bit_rise;
   logic [1:0] tx_lock_lost_bit_fall;
   logic [1:0] fierr_rise;
   logic [1:0] tx_lock_lost_bit_set;
   logic [1:0] fierr_set;
   logic [7:0] ev_now;

   assign ref_tick   = pins_f.ref_level & ~st_q.prev.ref_level;
   assign rec_tick   = pins_f.rec_mark & ~st_q.prev.rec_mark;
   assign los_rise   = pins_f.los & ~st_q.prev.los;
   assign lol_rise   = lol & ~st_q.lol_prev;
   assign tx_lock_lost_bit_rise = pins_f.tx_lol & ~st_q.prev.tx_lol;
   assign tx_lock_lost_bit_fall = ~pins_f.tx_lol & st_q.prev.tx_lol;
   assign fierr_rise = pins_f.fierr & ~st_q.prev.fierr;
   assign ev_now     = {fierr_rise, tx_lock_lost_bit_rise, lol_rise, los_rise};

   // only enabled causes raise a fault
   always_comb begin
      for (int c = 0; c < `CH_COUNT; c++) begin
         tx_lock_lost_bit_set[c] = tx_lock_lost_bit_rise[c] & st_q.fault_en[2*c+`FEN_TX_LOCK_LOST_BIT];
         fierr_set[c] = fierr_rise[c] & st_q.fault_en[2*c+`FEN_FIERR];
      end
   end

   // ======================================================
   // lock monitors
   for (genvar c = 0; c < `CH_COUNT; c++) begin : g_mon
      ppm_lock_monitor #(
         .WIN_TICKS (WIN_TICKS)
      ) u_mon (
         .clk       (clk),
         .reset     (rst_int),
         .ref_tick  (ref_tick),
         .rec_tick  (rec_tick[c]),
         .lock_lost (lol[c])
      );
   end

   // ======================================================
   // apb decode
   logic        acc;
   logic        setup;
   logic        acc_wr;
   logic        fault_read;
   logic [7:0]  ev_clr;
   logic [31:0] rdata;
   logic        rerr;

   assign acc        = psel & penable;
   assign setup      = psel & ~penable;
   assign acc_wr     = acc & pwrite;
   assign fault_read = acc & ~pwrite & (paddr == `REG_FAULT_STAT);
   assign ev_clr     = (acc_wr && paddr == `REG_IRQ_CLEAR) ?
                       pwdata[7:0] : 8'h00;

   // read data is taken in setup so it stands through access
   always_comb begin
      rdata = '0;
      rerr  = 1'b0;
      case (paddr)
         `REG_FAULT_STAT: begin
            rdata[`FS_TX_LOCK_LOST_BIT_PEND +: 2] = st_q.tx_lock_lost_bit_pend;
            rdata[`FS_FIERR_PEND +: 2] = st_q.fierr_pend;
            rdata[`FS_TX_LOCK_LOST_BIT_LIVE +: 2] = pins_f.tx_lol;
            rdata[`FS_LOS_LIVE +: 2]   = pins_f.los;
            rdata[`FS_LOL_LIVE +: 2]   = lol;
            rdata[`FS_REF_SEL +: 2]    = st_q.ref_sel;
            rdata[`FS_IRQ_N +: 2]      = st_q.tx_irq_n;
         end
         `REG_FAULT_EN: begin
            rdata[3:0] = st_q.fault_en;
         end
         `REG_IRQ_STATUS: begin
            rdata[7:0] = st_q.ev_sticky;
         end
         `REG_IRQ_CLEAR: begin
            rdata = '0;
         end
         `REG_IRQ_ENABLE: begin
            rdata[7:0] = st_q.irq_en;
         end
         default: begin
            rerr = 1'b1;
         end
      endcase
   end

   // ======================================================
   // next state
   always_comb begin
      st_d          = st_q;
      st_d.prev     = pins_f;
      st_d.lol_prev = lol;

      if (!st_q.started) begin
         st_d.started = 1'b1;
         case (pins_f.ref_sel)
            2'b00: st_d.ref_sel = line_irq_pkg::ref_sel_low;
            2'b01: st_d.ref_sel = line_irq_pkg::ref_sel_float;
            default: st_d.ref_sel = line_irq_pkg::ref_sel_high;
         endcase
      end

      if (setup) begin
         st_d.prdata  = rdata;
         st_d.pslverr = rerr;
      end
      if (acc_wr && paddr == `REG_FAULT_EN) begin
         st_d.fault_en = pwdata[3:0];
      end
      if (acc_wr && paddr == `REG_IRQ_ENABLE) begin
         st_d.irq_en = pwdata[7:0];
      end

      for (int c = 0; c < `CH_COUNT; c++) begin
         // pending until a clear; set wins
         st_d.tx_lock_lost_bit_pend[c] = (st_q.tx_lock_lost_bit_pend[c] &
                               ~(fault_read | tx_lock_lost_bit_fall[c]))
                              | tx_lock_lost_bit_set[c];
         st_d.fierr_pend[c] = (st_q.fierr_pend[c] &
                               ~(fault_read | tx_lock_lost_bit_fall[c] |
                                 pins_f.realign[c]))
                              | fierr_set[c];
      end
      st_d.tx_irq_n = ~(st_d.tx_lock_lost_bit_pend | st_d.fierr_pend);

      // sticky events, a new event beats the clear
      st_d.ev_sticky = (st_q.ev_sticky & ~ev_clr) | ev_now;
      st_d.irq       = |(st_d.ev_sticky & st_d.irq_en);

      if (rst_int) begin
         st_d          = '0;
         st_d.fault_en = `FAULT_EN_RESET;
         st_d.irq_en   = `IRQ_EN_RESET;
         st_d.tx_irq_n = 2'b11;
         // monitors show lost in reset: no false rise on release
         st_d.lol_prev = 2'b11;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   // ======================================================
   // outputs
   assign prdata  = st_q.prdata;
   assign pready  = acc;
   assign pslverr = acc & st_q.pslverr;
   assign irq     = st_q.irq;

   assign rx_signal_lost_out = pins_f.los;
   assign rx_lock_lost_out   = lol;
   assign tx_fault_irq_n     = st_q.tx_irq_n;
   assign rx_fault_irq_n     = 2'b11;

   // ======================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_lol_raise;
      tx_lock_lost_bit_rise[0] && st_q.fault_en[`FEN_TX_LOCK_LOST_BIT] && !rst_int;
   endsequence

   sequence s_irq_low;
      !tx_fault_irq_n[0];
   endsequence

   sequence s_no_new_fault;
      !(|tx_lock_lost_bit_set) && !(|fierr_set);
   endsequence

   AST_LOS_EVENT: assert property (
      $rose(pins_f.los[0]) && !rst_int
      |=> st_q.ev_sticky[`EV_LOS] && rx_signal_lost_out[0])
      else $error("signal loss not reported");

   AST_TX_IRQ_SET: assert property (
      s_lol_raise |=> s_irq_low)
      else $error("fault interrupt not raised");

   AST_STAT_READ: assert property (
      fault_read && !rst_int ##0 s_no_new_fault
      |=> tx_fault_irq_n == 2'b11)
      else $error("status read did not release interrupt");

   AST_REALIGN_CLR: assert property (
      pins_f.realign[0] && !fierr_set[0]
      |=> !st_q.fierr_pend[0])
      else $error("realign did not clear fifo error");

   AST_LOCK_REGAIN: assert property (
      tx_lock_lost_bit_fall[0] && !fierr_set[0] |=> tx_fault_irq_n[0])
      else $error("lock regain did not clear interrupt");

   AST_RESET_EN: assert property (
      rst_int |=> st_q.fault_en == `FAULT_EN_RESET)
      else $error("fault enables wrong after reset");

   AST_RX_IRQ_IDLE: assert property (
      rx_fault_irq_n == 2'b11)
      else $error("reserved interrupt asserted");

   AST_POR_HOLD: assert property (
      !pins_f.por_n
      |=> tx_fault_irq_n == 2'b11 && !irq &&
          st_q.ev_sticky == 8'h00)
      else $error("power-on reset did not hold logic");

   AST_REF_SEL_HOLD: assert property (
      st_q.started && !rst_int |=> $stable(st_q.ref_sel))
      else $error("reference selection changed outside reset");

   AST_PEND_HOLD: assert property (
      st_q.tx_lock_lost_bit_pend[0] && !fault_read && !tx_lock_lost_bit_fall[0] &&
      !rst_int |=> st_q.tx_lock_lost_bit_pend[0] [*1] ##0 s_irq_low)
      else $error("fault interrupt dropped without a clear");

endmodule // line_status_and_fault_irq

// [sim/line_far_end.sv]
// far-end model: reference and recovered clock marks
`timescale 1ns/100ps
module line_far_end #(
   parameter int MARK = 8,
   parameter int SLOW = 12
) (
   input  wire logic       clk,
   input  wire logic [1:0] slow,
   output logic            ref_pos,
   output logic            ref_neg,
   output logic [1:0]      rec
);
   int rc;
   int cc [2];
   // ======================================================
   // marks, slow enough for the pin filter
   initial begin
      rc = 0;
      cc = '{0, 0};
      ref_pos = 1'b0;
      ref_neg = 1'b1;
      rec = 2'h0;
   end
   always @(posedge clk) begin
      rc = (rc + 1) % MARK;
      ref_pos <= (rc < MARK / 2);
      ref_neg <= !(rc < MARK / 2);
      // a slow channel drifts far past any ppm tolerance
      for (int c = 0; c < 2; c++) begin
         cc[c] = (cc[c] + 1) % (slow[c] ? SLOW : MARK);
         rec[c] <= (cc[c] < MARK / 2);
      end
   end
endmodule // line_far_end

// [sim/tb_top.sv]
// testbench for the line status and fault interrupt block
`timescale 1ns/100ps
`include "line_irq_defs.svh"
module tb_top;
   // ======================================================
   // signals
   logic        clk, reset, psel, penable, pwrite, por_n, er;
   logic [7:0]  paddr, en;
   logic [31:0] pwdata, prdata, rd, seed;
   logic        pready, pslverr, irq, ref_p, ref_n;
   logic [1:0]  ref_sel, los, rec, tlol, ferr, realign, slow;
   logic [1:0]  los_o, lol_o, txirq_n, rxirq_n;
   int          fail_count, comparisons;

   // small window keeps lock checks short; tolerance is then zero
   line_status_and_fault_irq #(.WIN_TICKS(16)) u_dut (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .power_on_reset_n(por_n), .ref_clock_in_pos(ref_p),
      .ref_clock_in_neg(ref_n), .ref_freq_select(ref_sel),
      .rx_los_detect(los), .rec_clock_mark(rec),
      .tx_cdr_lock_lost(tlol), .fifo_error_flag(ferr),
      .fifo_realign_ctl(realign), .rx_signal_lost_out(los_o),
      .rx_lock_lost_out(lol_o), .tx_fault_irq_n(txirq_n),
      .rx_fault_irq_n(rxirq_n));

   line_far_end u_far (.clk(clk), .slow(slow), .ref_pos(ref_p),
      .ref_neg(ref_n), .rec(rec));

   // ======================================================
   // helpers
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   function automatic logic exp_irq(logic [7:0] st, logic [7:0] e);
      return |(st & e);
   endfunction

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(int k);
      repeat (k) @(posedge clk);
   endtask

   // apb master: hold the request until pready is seen at an edge
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end

   // ======================================================
   // main sequence
   initial begin
      seed = 32'h7692bb8e;
      {reset, psel, penable, pwrite, por_n} = 5'h11;
      paddr = 8'h00;
      pwdata = 32'h0;
      ref_sel = 2'h2;
      {los, tlol, ferr, realign, slow} = 10'h000;
      fail_count = 0;
      comparisons = 0;
      cyc(3);
      reset <= 1'b0;
      cyc(8);
      apb(0, `REG_FAULT_EN, 0);
      check("fault_en", rd, 32'h5);
      apb(0, `REG_IRQ_ENABLE, 0);
      check("irq_en", rd, 32'h0);
      check("rx_irq_n", rxirq_n, 2'h3);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         los <= seed[1:0];
         cyc(8);
         check("los_out", los_o, seed[1:0]);
      end
      los <= 2'h0;
      cyc(8);
      // sticky events, enable, clear, unmapped place
      seed = xs(seed);
      en = {seed[7:6], 4'h0, seed[1:0]};
      apb(1, `REG_IRQ_CLEAR, 32'hff);
      apb(1, `REG_IRQ_ENABLE, {24'h0, en});
      los <= 2'h3;
      cyc(8);
      apb(0, `REG_IRQ_STATUS, 0);
      check("irq_status", rd[1:0], 2'h3);
      check("irq", irq, exp_irq(8'h03, en));
      apb(1, `REG_IRQ_CLEAR, 32'h3);
      apb(0, `REG_IRQ_CLEAR, 0);
      check("clear_reads", rd, 32'h0);
      check("irq_cleared", irq, exp_irq(8'h00, en));
      apb(0, 8'h20, 0);
      check("unmapped_err", er, 1'b1);
      check("unmapped_rd", rd, 32'h0);
      // only lock loss raises the interrupt after reset
      ferr <= 2'h1;
      cyc(8);
      check("txirq_default", txirq_n, 2'h3);
      ferr <= 2'h0;
      apb(1, `REG_FAULT_EN, 32'hf);
      ferr <= 2'h2;
      cyc(4);
      ferr <= 2'h0;
      cyc(8);
      check("txirq_fifo", txirq_n, 2'h1);
      cyc(20);
      check("txirq_hold", txirq_n, 2'h1);
      realign <= 2'h2;
      cyc(8);
      check("txirq_realign", txirq_n, 2'h3);
      apb(0, `REG_FAULT_STAT, 0);
      check("fierr_pend", rd[3:2], 2'h0);
      realign <= 2'h0;
      // both causes on one channel: realign leaves lock cause
      tlol <= 2'h1;
      ferr <= 2'h1;
      cyc(8);
      realign <= 2'h1;
      cyc(8);
      check("txirq_mixed", txirq_n, 2'h2);
      realign <= 2'h0;
      ferr <= 2'h0;
      apb(0, `REG_FAULT_STAT, 0);
      // signal loss on both channels is still live from above
      check("stat_pend", rd[13:0], 14'h28d1);
      cyc(2);
      check("txirq_read", txirq_n, 2'h3);
      tlol <= 2'h3;
      cyc(8);
      check("txirq_lol", txirq_n, 2'h1);
      tlol <= 2'h0;
      cyc(8);
      check("txirq_regain", txirq_n, 2'h3);
      slow <= 2'h2;
      cyc(600);
      check("lock_lost", lol_o, 2'h2);
      // strap change is ignored until power-on reset rises
      ref_sel <= 2'h0;
      apb(1, `REG_FAULT_EN, 32'h0);
      tlol <= 2'h1;
      cyc(8);
      apb(0, `REG_FAULT_STAT, 0);
      check("ref_sel_held", rd[11:10], 2'h2);
      apb(1, `REG_FAULT_EN, 32'hf);
      tlol <= 2'h2;
      cyc(8);
      por_n <= 1'b0;
      cyc(8);
      check("por_txirq", txirq_n, 2'h3);
      tlol <= 2'h0;
      cyc(8);
      por_n <= 1'b1;
      cyc(10);
      apb(0, `REG_FAULT_EN, 0);
      check("por_fault_en", rd, 32'h5);
      apb(0, `REG_FAULT_STAT, 0);
      check("ref_sel_new", rd[11:10], 2'h0);
      // float strap is taken on the next reset rise
      ref_sel <= 2'h1;
      por_n <= 1'b0;
      cyc(8);
      por_n <= 1'b1;
      cyc(10);
      apb(0, `REG_FAULT_STAT, 0);
      check("ref_sel_float", rd[11:10], 2'h1);
      report_and_stop;
   end
endmodule // tb_top
